// ### rtl/wdt_top.sv
// Windowed watchdog timer with service register and access checking.
//
// Notes on behaviour
// R01: Writing key ACH clears the counter and restarts counting from zero.
// R02: Service register resets to 1AH when disabled, 9AH when enabled.
// R03: Any write other than ACH requests an internal reset.
// R04: Violations while the slow clock stops fire once it runs again.
// R05: A single-bit manipulation of the service register causes a reset.
// R06: Reads return 9AH or 1AH per the enable option, never the key.
// R07: Option bit 4 enables counting and illegal-access detection from reset.
// R08: Except the first service, writes in the closed window cause reset.
// R09: Reaching the overflow time without a valid key causes reset.
// R10: Fetch outside the configured memory area causes reset when enabled.
// R11: Data access outside the area causes reset, FB00H-FFFFH exempt.
// R12: First key write after reset clears the counter at any window time.
// R13: A service just before the count overflows still clears it.
// R14: Option bits 3..1 select overflow of 2^(10+n) slow periods.
// R15: Option bits 6..5 open the final 25/50/75/100 percent of the period.
// R16: Software never combines select zero with window code zero.
// R17: Lock option 0 stops counting in halt and stop; 1 keeps counting.
// R18: After halt or stop, counting resumes from the held count.
// R19: Stopping the slow oscillator with lock option 0 freezes the count.
// R20: Counting continues during self-programming and memory emulation.
// R21: After a clear, overflow may shift by at most two slow periods.
// R22: The counter advances on the low-speed oscillator rate only.
// R23: A watchdog reset sets the reset-cause flag.
// R24: Service writes pass into the slow timing before acting; reset is synchronous.
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_top #(
  parameter int TICK_DIV = `WDT_TICK_DIV,
  parameter int CNT_W    = `WDT_CNT_W
) (
  input  wire logic               clk,          // 10 MHz system clock.
  input  wire logic               rst_n,        // Synchronous reset, low.
  input  wire wdt_pkg::wdt_option_t opt_byte,   // Option byte, latched.
  input  wire wdt_pkg::wdt_bus_t   bus,          // CPU bus cycle.
  input  wire wdt_pkg::wdt_area_t  area,         // Legal memory area.
  input  wire logic               halt_mode,    // CPU in halt mode.
  input  wire logic               stop_mode,    // CPU in stop mode.
  input  wire logic               slow_osc_stop_ctl, // Oscillator stop.
  input  wire logic               self_prog,    // Flash self-programming.
  output logic [7:0]              rdata,        // Service register read.
  output logic                    reset_req,    // Internal reset request.
  output logic                    watchdog_reset_cause_flag // Cause set.
);
  import wdt_pkg::*;

  wdt_option_t        opt;
  wdt_state_t         state;
  logic [CNT_W-1:0]   count;
  logic               clr_pend;
  logic               viol_pend;
  logic               slow_run;
  logic               tick;
  logic               area_bad;
  logic               enabled;
  logic               svc_hit;
  logic               key_ok;
  logic [2:0]         sel;
  logic [1:0]         span;
  logic [CNT_W:0]     limit;
  logic [CNT_W:0]     quarter;
  logic [CNT_W:0]     close_len;
  logic               closed;
  logic               at_last;
  logic [7:0]         reset_val;

  // Option byte is caught while reset is held, so it is stable after.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      opt <= opt_byte;
  end

  assign enabled   = opt.watchdog_run_option;                       // R07
  assign reset_val = enabled ? `WDT_RESET_VAL_RUN
                             : `WDT_RESET_VAL_OFF;                   // R02
  assign sel  = {opt.overflow_select_b2, opt.overflow_select_b1,
                 opt.overflow_select_b0};
  assign span = {opt.open_span_b1, opt.open_span_b0};

  // Overflow limit and closed length, both in slow periods.
  assign limit     = (CNT_W+1)'(1) << (`WDT_OVF_EXP_BASE + 32'(sel)); // R14
  assign quarter   = limit >> 2;
  assign close_len = limit - quarter * (CNT_W+1)'({1'b0, span} + 3'd1); // R15
  assign closed    = ({1'b0, count} < close_len);
  assign at_last   = ({1'b0, count} == limit - (CNT_W+1)'(1));

  // Without the lock option, halt, stop or a software stop freeze
  // the slow clock; self-programming has no effect on it.
  assign slow_run = opt.slow_osc_lock_option ||
                    !(halt_mode || stop_mode || slow_osc_stop_ctl); // R17 R19 R20

  // Slow-rate enable: the counter never advances on the CPU clock.
  wdt_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (slow_run),
    .tick  (tick)                                                   // R22
  );

  // Out-of-area fetch and data access detector.
  wdt_check u_check (
    .clk   (clk),
    .rst_n (rst_n),
    .arm   (enabled && state != WDT_IDLE),
    .bus   (bus),
    .area  (area),
    .bad   (area_bad)
  );

  assign svc_hit = bus.wr && (bus.addr == `WDT_SERVICE_ADDR);
  assign key_ok  = !bus.bitop && (bus.wdata == `WDT_SERVICE_KEY);

  // A valid key is held until the next slow tick applies it; this
  // resynchronisation costs up to two slow periods of accuracy. A new
  // write in the tick cycle wins over the consumption.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      clr_pend <= 1'b0;
    else if (svc_hit && key_ok && state == WDT_FIRST)
      clr_pend <= 1'b1;                                             // R12 R24
    else if (svc_hit && key_ok && state == WDT_ARMED && !closed)
      clr_pend <= 1'b1;                                             // R01 R24
    else if (tick)
      clr_pend <= 1'b0;                                             // R21
  end

  // Violations are held and only turn into a reset on a slow tick, so
  // a stopped oscillator delays them until it runs again.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      viol_pend <= 1'b0;
    else if (state == WDT_FIRST || state == WDT_ARMED)
    begin
      if (svc_hit && !key_ok)
        viol_pend <= 1'b1;                                          // R03 R05
      else if (svc_hit && state == WDT_ARMED && closed)
        viol_pend <= 1'b1;                                          // R08
      else if (area_bad)
        viol_pend <= 1'b1;                                          // R10 R11
    end
  end

  // Sequence: idle when disabled, first service pending, then armed.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= WDT_IDLE;
    else
    begin
      unique case (state)
        WDT_IDLE:
          if (enabled)
            state <= WDT_FIRST;                                     // R07
        WDT_FIRST:
          if (tick && viol_pend)
            state <= WDT_FIRED;                                     // R04
          else if (tick && clr_pend)
            state <= WDT_ARMED;                                     // R12
          else if (tick && at_last)
            state <= WDT_FIRED;                                     // R09
        WDT_ARMED:
          if (tick && (viol_pend || (at_last && !clr_pend)))
            state <= WDT_FIRED;                                     // R04 R09
        WDT_FIRED:
          state <= WDT_FIRED;
      endcase
    end
  end

  // Counter: cleared by an applied key, even at the last count; frozen
  // between ticks, so halt and stop with lock option 0 keep the held value.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count <= '0;
    else if (tick && (state == WDT_FIRST || state == WDT_ARMED))
    begin
      if (clr_pend)
        count <= '0;                                                // R01 R13
      else if (!at_last)
        count <= count + CNT_W'(1);                                 // R18 R22
    end
  end

  // Reset request and cause flag hold until the chip reset takes hold.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reset_req                 <= 1'b0;
      watchdog_reset_cause_flag <= 1'b0;
    end
    else if (state == WDT_FIRED)
    begin
      reset_req                 <= 1'b1;                            // R24
      watchdog_reset_cause_flag <= 1'b1;                            // R23
    end
  end

  // Reads always show the reset-time value, never the written key.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (bus.rd && bus.addr == `WDT_SERVICE_ADDR)
      rdata <= reset_val;                                           // R06
    else
      rdata <= 8'h00;
  end
endmodule // wdt_top

// ### rtl/wdt_map.svh
// Address, key, field and timing constants of the windowed watchdog.
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Register address and values.
`define WDT_SERVICE_ADDR   16'hFF99
`define WDT_SERVICE_KEY    8'hAC
`define WDT_RESET_VAL_RUN  8'h9A
`define WDT_RESET_VAL_OFF  8'h1A
`define WDT_EXEMPT_BASE    16'hFB00

// Option byte field positions.
`define WDT_OPT_LOCK_BIT   0
`define WDT_OPT_SEL_LSB    1
`define WDT_OPT_SEL_MSB    3
`define WDT_OPT_RUN_BIT    4
`define WDT_OPT_SPAN_LSB   5
`define WDT_OPT_SPAN_MSB   6

// Overflow time is 2^(base + select) slow periods.
`define WDT_OVF_EXP_BASE   10
`define WDT_CNT_W          17

// Timing: system clock and nominal low-speed oscillator rate in Hz.
`define WDT_CLK_HZ         10000000
`define WDT_SLOW_OSC_HZ    240000
`define WDT_TICK_DIV       (`WDT_CLK_HZ / `WDT_SLOW_OSC_HZ)

`endif

// ### rtl/wdt_pkg.sv
// Types shared by the windowed watchdog modules.
package wdt_pkg;

  // Option byte as latched at reset, bit 7 first.
  typedef struct packed {
    logic       spare;
    logic       open_span_b1;
    logic       open_span_b0;
    logic       watchdog_run_option;
    logic       overflow_select_b2;
    logic       overflow_select_b1;
    logic       overflow_select_b0;
    logic       slow_osc_lock_option;
  } wdt_option_t;

  // One CPU bus cycle as seen by the watchdog.
  typedef struct packed {
    logic        fetch;
    logic        rd;
    logic        wr;
    logic        bitop;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } wdt_bus_t;

  // Legal memory area handed over by the memory-size logic.
  typedef struct packed {
    logic [15:0] code_top;
    logic [15:0] ram_bottom;
  } wdt_area_t;

  // Gray-coded watchdog sequence.
  typedef enum logic [1:0] {
    WDT_IDLE  = 2'b00,
    WDT_FIRST = 2'b01,
    WDT_ARMED = 2'b11,
    WDT_FIRED = 2'b10
  } wdt_state_t;

endpackage

// ### rtl/wdt_tick.sv
// Low-speed oscillator stand-in: an enable pulse once per slow period.
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_tick #(
  parameter int DIV = `WDT_TICK_DIV
) (
  input  wire logic clk,   // System clock.
  input  wire logic rst_n, // Synchronous reset, active low.
  input  wire logic run,   // Oscillator running.
  output logic      tick   // One-cycle pulse per slow period.
);
  logic [15:0] div_cnt;

  // A stopped oscillator holds its phase, so no tick is lost or gained.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end
    else if (run)
    begin
      tick    <= (div_cnt == 16'(DIV - 1));
      div_cnt <= (div_cnt == 16'(DIV - 1)) ? 16'h0000 : div_cnt + 16'h0001;
    end
    else
    begin
      tick <= 1'b0;
    end
  end
endmodule // wdt_tick

// ### rtl/wdt_check.sv
// Illegal fetch and data access detector against the legal area.
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_check (
  input  wire logic              clk,   // System clock.
  input  wire logic              rst_n, // Synchronous reset, active low.
  input  wire logic              arm,   // Detection enabled.
  input  wire wdt_pkg::wdt_bus_t  bus,   // CPU bus cycle.
  input  wire wdt_pkg::wdt_area_t area,  // Legal area bounds.
  output logic                   bad    // One-cycle pulse on violation.
);
  import wdt_pkg::*;

  logic in_area;
  logic exempt;

  // Legal area is code below code_top plus RAM from ram_bottom upward.
  assign in_area = (bus.addr < area.code_top) ||
                   (bus.addr >= area.ram_bottom);
  assign exempt  = (bus.addr >= `WDT_EXEMPT_BASE);

  // Fetches get no exemption; data accesses spare the top block.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bad <= 1'b0;
    else
      bad <= arm && !in_area &&
             (bus.fetch || ((bus.rd || bus.wr) && !exempt)); // R10 R11
  end
endmodule // wdt_check

// ### verification/wdt_top_props.sv
// Port checks for the windowed watchdog.
`timescale 1ns/1ps
`include "wdt_map.svh"
module wdt_top_props #(
  parameter int TICK_DIV = 2
) (
  input wire logic                 clk,       // Clock.
  input wire logic                 rst_n,     // Reset, low.
  input wire wdt_pkg::wdt_option_t opt_byte,  // Option byte.
  input wire wdt_pkg::wdt_bus_t    bus,       // Bus cycle.
  input wire wdt_pkg::wdt_area_t   area,      // Legal area.
  input wire logic                 halt_mode, // Halt.
  input wire logic                 stop_mode, // Stop.
  input wire logic                 slow_osc_stop_ctl, // Osc stop.
  input wire logic [7:0]           rdata,     // Read data.
  input wire logic                 reset_req, // Reset request.
  input wire logic                 watchdog_reset_cause_flag // Cause.
);
  import wdt_pkg::*;
  localparam int LAT = TICK_DIV + 4;
  logic run_q;
  logic lock_q;
  logic halted;
  logic hit;
  // Options are caught during reset, the same moment the block takes them.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      run_q  <= opt_byte.watchdog_run_option;
      lock_q <= opt_byte.slow_osc_lock_option;
    end
  end
  // A held slow clock delays every verdict, so those cases are left out.
  assign halted = !lock_q && (halt_mode || stop_mode || slow_osc_stop_ctl);
  assign hit = bus.wr && bus.addr == `WDT_SERVICE_ADDR && run_q && !halted;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_read_value: assert property (bus.rd && bus.addr == `WDT_SERVICE_ADDR
    |=> rdata == (run_q ? `WDT_RESET_VAL_RUN : `WDT_RESET_VAL_OFF))
    else $error("service read value wrong");
  a_read_idle: assert property (!(bus.rd && bus.addr == `WDT_SERVICE_ADDR)
    |=> rdata == 8'h00) else $error("idle read data not zero");
  a_req_sticky: assert property (reset_req |=> reset_req)
    else $error("reset request dropped");
  a_cause_flag: assert property (watchdog_reset_cause_flag == reset_req)
    else $error("cause flag differs from request");
  a_off_silent: assert property (!run_q |-> !reset_req)
    else $error("reset while disabled");
  a_bad_key: assert property (hit && bus.wdata != `WDT_SERVICE_KEY
    |-> ##[1:LAT] reset_req) else $error("wrong key not punished");
  a_bit_write: assert property (hit && bus.bitop
    |-> ##[1:LAT] reset_req) else $error("bit write not punished");
  a_halt_hold: assert property (halted && $past(halted) && $past(halted, 2)
    && $past(halted, 3) |-> !$rose(reset_req))
    else $error("reset while slow clock held");
  a_fetch_out: assert property (bus.fetch && run_q && !halted
    && bus.addr >= area.code_top && bus.addr < area.ram_bottom
    |-> ##[1:LAT] reset_req) else $error("bad fetch missed");
endmodule // wdt_top_props

bind wdt_top wdt_top_props #(.TICK_DIV(TICK_DIV)) u_props (
  .clk(clk), .rst_n(rst_n), .opt_byte(opt_byte), .bus(bus), .area(area),
  .halt_mode(halt_mode), .stop_mode(stop_mode),
  .slow_osc_stop_ctl(slow_osc_stop_ctl), .rdata(rdata),
  .reset_req(reset_req),
  .watchdog_reset_cause_flag(watchdog_reset_cause_flag));

// ### verification/windowed_watchdog_timer_tb_top.sv
// Self-checking bench for the windowed watchdog.
`timescale 1ns/1ps
`include "wdt_map.svh"
module windowed_watchdog_timer_tb_top;
  import wdt_pkg::*;
  localparam int TD  = 2;
  localparam int OVF = 1024 * TD;
  localparam logic [15:0] AD = `WDT_SERVICE_ADDR;
  localparam logic [7:0]  KY = `WDT_SERVICE_KEY;
  logic clk, rst_n, halt_mode, stop_mode, slow_osc_stop_ctl, self_prog;
  logic reset_req, flag;
  logic [7:0] rdata;
  logic [7:0] d;
  wdt_option_t opt_byte;
  wdt_bus_t bus;
  wdt_area_t area;
  int failures, n_tests, cl;
  wdt_top #(.TICK_DIV(TD)) DUT (.clk(clk), .rst_n(rst_n),
    .opt_byte(opt_byte), .bus(bus), .area(area), .halt_mode(halt_mode),
    .stop_mode(stop_mode), .slow_osc_stop_ctl(slow_osc_stop_ctl),
    .self_prog(self_prog), .rdata(rdata), .reset_req(reset_req),
    .watchdog_reset_cause_flag(flag));
  // Free-running system clock.
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Option byte from its fields; select zero never meets window zero.
  function automatic logic [7:0] ob(int w, int r, int s, int l);
    if (s == 0 && w == 0)
      w = 1;
    ob = {1'b0, w[1:0], r[0], s[2:0], l[0]};
  endfunction
  // Closed span in cycles: the open part is the final quarter steps.
  function automatic int close_len(int w);
    close_len = (1024 - 256 * (w + 1)) * TD;
  endfunction
  task automatic stop_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic rst(logic [7:0] o);
    rst_n <= 1'b0;
    opt_byte <= wdt_option_t'(o);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // One bus cycle; k is fetch, rd, wr, bitop.
  task automatic acc(logic [3:0] k, logic [15:0] a, logic [7:0] v);
    bus <= wdt_bus_t'({k, a, v});
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd_chk(logic [7:0] e);
    bus <= wdt_bus_t'({4'b0100, AD, 8'h00});
    @(posedge clk);
    bus <= '0;
    #1;
    n_tests++;
    if (rdata !== e)
    begin
      failures++;
      $display("BAD rdata exp %h got %h", e, rdata);
    end
    @(posedge clk);
  endtask
  // Waits up to n cycles for a request, then compares.
  task automatic exp_req(int n, logic e);
    int i;
    i = 0;
    while (i < n && reset_req !== 1'b1)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    n_tests++;
    if (reset_req !== e || flag !== e)
    begin
      failures++;
      $display("BAD reset_req exp %b got %b", e, reset_req);
    end
  endtask
  // Hang guard sized well beyond the planned run.
  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    stop_test;
  end
  initial
  begin
    rst_n = 1'b0;
    opt_byte = '0;
    bus = '0;
    area = '{code_top: 16'h4000, ram_bottom: 16'hFF00};
    {halt_mode, stop_mode, slow_osc_stop_ctl, self_prog} = 4'h0;
    void'($urandom(21));
    // Disabled: off value, bad key ignored, no overflow.
    rst(ob(3, 0, 0, 0));
    rd_chk(`WDT_RESET_VAL_OFF);
    acc(4'h2, AD, 8'h55);
    exp_req(OVF + 100, 1'b0);
    // First service at a random time, second just before overflow.
    rst(ob(3, 1, 0, 0));
    rd_chk(`WDT_RESET_VAL_RUN);
    repeat ($urandom_range(1, 300)) @(posedge clk);
    acc(4'h2, AD, KY);
    rd_chk(`WDT_RESET_VAL_RUN);
    repeat (OVF - 20) @(posedge clk);
    acc(4'h2, AD, KY);
    self_prog <= 1'b1;
    exp_req(OVF - 2 * TD - 16, 1'b0);
    exp_req(40, 1'b1);
    self_prog <= 1'b0;
    // Window codes: open write passes, a quick repeat is punished except under code 3.
    for (int w = 1; w < 4; w++)
    begin
      cl = close_len(w);
      rst(ob(w, 1, 0, 0));
      acc(4'h2, AD, KY);
      repeat (cl + 40) @(posedge clk);
      acc(4'h2, AD, KY);
      exp_req(20, 1'b0);
      acc(4'h2, AD, KY);
      exp_req(20, w != 3);
    end
    // Random wrong keys, then a bit write of the right key.
    for (int k = 0; k < 5; k++)
    begin
      rst(ob(3, 1, 0, 1));
      d = $urandom_range(0, 255);
      if (d == KY)
        d = 8'h00;
      acc(k == 4 ? 4'h3 : 4'h2, AD, k == 4 ? KY : d);
      exp_req(20, 1'b1);
    end
    // Exempt data range stays quiet; outside fetch or write resets.
    rst(ob(3, 1, 0, 0));
    acc(4'h4, 16'hFB00 + 16'($urandom_range(0, 1023)), 8'h00);
    acc(4'h2, 16'hFB00 + 16'($urandom_range(0, 1023)), 8'h3C);
    exp_req(30, 1'b0);
    for (int j = 0; j < 2; j++)
    begin
      rst(ob(3, 1, 0, 0));
      acc(j == 0 ? 4'h8 : 4'h2, 16'h8000, 8'h00);
      exp_req(20, 1'b1);
    end
    // Held slow clock defers the verdict; lock option keeps it running.
    for (int m = 0; m < 4; m++)
    begin
      rst(ob(3, 1, 0, m == 3));
      {slow_osc_stop_ctl, stop_mode, halt_mode} <= 3'b001 << (m % 3);
      acc(4'h2, AD, 8'h55);
      exp_req(40, m == 3);
      {slow_osc_stop_ctl, stop_mode, halt_mode} <= 3'b000;
      exp_req(20, 1'b1);
    end
    stop_test;
  end
endmodule // windowed_watchdog_timer_tb_top
